// ===== occ_pkg.sv
// package and command serializer of the oscillator command and gain control block
`default_nettype none

package occ_pkg;

    // clock and timing
    localparam int CLK_MHZ   = 125;
    localparam int DELAY_US  = 7000;
    localparam int DELAY_CYC = DELAY_US * CLK_MHZ;
    localparam int ENV_US    = 20;
    localparam int ENV_CYC   = ENV_US * CLK_MHZ;

    // command word
    localparam int          CMD_W        = 16;
    localparam int          BIT_CYC      = ENV_CYC / CMD_W;
    localparam int          DEST_W       = 3;
    localparam logic [2:0]  DEST_DEFAULT = 3'h4;
    localparam logic [15:0] FREQ_RST     = 16'h0000;
    localparam logic [2:0]  DEST_RST     = 3'h4;

    // gain loop
    localparam int         STEP_DB   = 11;
    localparam int         RANGE_DB  = 44;
    localparam logic [2:0] LEVEL_MAX = 3'(RANGE_DB / STEP_DB);
    localparam logic [2:0] LEVEL_RST = 3'h0;
    localparam logic [1:0] LIMIT_RST = 2'h0;
    localparam logic [1:0] HIST_FULL = 2'h3;

    // register map, byte addresses
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_FREQ   = 8'h04;
    localparam logic [7:0] REG_DEST   = 8'h08;
    localparam logic [7:0] REG_LIMIT  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // ctrl fields
    localparam int         CTRL_HRR_BIT = 0;
    localparam int         CTRL_FMR_BIT = 1;
    localparam logic       CTRL_RST     = 1'b0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } occ_bus_t;

    typedef struct packed {
        logic              window;
        logic [DEST_W-1:0] dest;
        logic              data;
        logic              shift;
    } occ_osc_t;

endpackage

module occ_ser
    import occ_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              start,
    input  wire logic [CMD_W-1:0]  word,
    input  wire logic [DEST_W-1:0] dest,
    output occ_osc_t               osc
);

    localparam logic [11:0] ENV_LOAD = 12'(ENV_CYC - 1);
    localparam logic [7:0]  BIT_LOAD = 8'(BIT_CYC - 1);
    localparam logic [4:0]  LAST_BIT = 5'(CMD_W - 1);

    typedef struct packed {
        logic              win;
        logic [DEST_W-1:0] dest;
        logic [CMD_W-1:0]  sr;
        logic [7:0]        bcnt;
        logic [11:0]       ecnt;
        logic [4:0]        nbit;
        logic              shift;
    } occ_ser_st_t;

    occ_ser_st_t s_q;
    occ_ser_st_t s_d;

    always_comb
    begin
        s_d       = s_q;
        s_d.shift = 1'b0;
        if (start && !s_q.win)
        begin
            // word and code frozen for the whole window
            s_d.win   = 1'b1;
            s_d.dest  = dest;
            s_d.sr    = word;
            s_d.ecnt  = ENV_LOAD;
            s_d.bcnt  = BIT_LOAD;
            s_d.nbit  = 5'h00;
            s_d.shift = 1'b1;
        end
        else if (s_q.win)
        begin
            if (s_q.ecnt == 12'h000)
                s_d.win = 1'b0;
            else
                s_d.ecnt = s_q.ecnt - 12'h001;
            if (s_q.bcnt == 8'h00 && s_q.nbit != LAST_BIT)
            begin
                s_d.bcnt  = BIT_LOAD;
                s_d.sr    = {s_q.sr[CMD_W-2:0], 1'b0};
                s_d.nbit  = s_q.nbit + 5'h01;
                s_d.shift = 1'b1;
            end
            else if (s_q.bcnt != 8'h00)
                s_d.bcnt = s_q.bcnt - 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            s_q <= '{win: 1'b0, dest: DEST_RST, sr: FREQ_RST, bcnt: 8'h00,
                     ecnt: 12'h000, nbit: 5'h00, shift: 1'b0};
        else
            s_q <= s_d;
    end

    // bits only move while the window is open
    assign osc = '{window: s_q.win, dest: s_q.dest, data: s_q.sr[CMD_W-1] & s_q.win,
                   shift: s_q.shift};

    logic [12:0] wcnt_q;
    logic [4:0]  scnt_q;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wcnt_q <= 13'h0000;
            scnt_q <= 5'h00;
        end
        else
        begin
            wcnt_q <= s_q.win ? wcnt_q + 13'h0001 : 13'h0000;
            scnt_q <= s_q.win ? scnt_q + 5'(s_q.shift) : 5'h00;
        end
    end

    property p_env_len;
        @(posedge clock) disable iff (!rstn)
        $fell(s_q.win) |-> wcnt_q == 13'(ENV_CYC);
    endproperty
    a_env_len: assert property (p_env_len) else $error("window length wrong");

    property p_bit_count;
        @(posedge clock) disable iff (!rstn)
        $fell(s_q.win) |-> scnt_q == 5'(CMD_W);
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("not sixteen bits");

    property p_win_seen;
        @(posedge clock) disable iff (!rstn)
        $rose(s_q.win);
    endproperty
    c_win_seen: cover property (p_win_seen);

endmodule

`default_nettype wire

// ===== occ_ctrl.sv
// top of the oscillator command and gain control block
`default_nettype none

module occ_ctrl
    import occ_pkg::*;
#(
    parameter int DELAY_CYCLES = DELAY_CYC
)
(
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire occ_bus_t   bus,
    output logic [31:0]     rdata,
    input  wire logic       phase_start,
    input  wire logic [1:0] threshold_level_status,
    output occ_osc_t        osc,
    output logic [2:0]      receiver_attenuation_code
);

    localparam int DW = $clog2(DELAY_CYCLES + 1);
    localparam logic [DW-1:0] DELAY_LOAD = DW'(DELAY_CYCLES - 3);

    typedef struct packed {
        logic          ph_meta;
        logic          ph_sync;
        logic          ph_prev;
        logic [1:0]    st_meta;
        logic [1:0]    st_sync;
        logic          hrr;
        logic          freq_mod_ranging;
        logic [15:0]   freq;
        logic          pending;
        logic [2:0]    dest;
        logic [1:0]    lim_reg;
        logic [1:0]    lim_q;
        logic [1:0]    h0;
        logic [1:0]    h1;
        logic [1:0]    h2;
        logic [1:0]    hcnt;
        logic [2:0]    level;
        logic [2:0]    atten;
        logic [DW-1:0] dcnt;
        logic          run;
        logic          start;
        logic [2:0]    send_dest;
        logic [31:0]   rdata;
    } occ_st_t;

    occ_st_t s_q;
    occ_st_t s_d;

    logic       ph_evt;
    logic [1:0] nhit;
    logic       up;
    logic       win_now;

    assign ph_evt = s_q.ph_sync & ~s_q.ph_prev;
    // hits over the window after the newest phase enters
    assign nhit = 2'(s_q.st_sync != 2'h0) + 2'(s_q.h0 != 2'h0) + 2'(s_q.h1 != 2'h0);
    assign up   = nhit >= 2'h2;

    always_comb
    begin
        s_d         = s_q;
        s_d.ph_meta = phase_start;
        s_d.ph_sync = s_q.ph_meta;
        s_d.ph_prev = s_q.ph_sync;
        s_d.st_meta = threshold_level_status;
        s_d.st_sync = s_q.st_meta;
        s_d.start   = 1'b0;
        s_d.rdata   = 32'h0000_0000;

        // delay is counted in hardware only; no register reaches it
        if (ph_evt)
        begin
            s_d.lim_q = s_q.lim_reg;
            s_d.h0    = s_q.st_sync;
            s_d.h1    = s_q.h0;
            s_d.h2    = s_q.h1;
            if (s_q.hcnt != HIST_FULL)
                s_d.hcnt = s_q.hcnt + 2'h1;
            if (s_q.pending)
            begin
                s_d.run  = 1'b1;
                s_d.dcnt = DELAY_LOAD;
            end
            // the window needs three phases before it may act
            if (s_q.hrr && s_q.hcnt >= 2'h2)
            begin
                if (up && s_q.level != LEVEL_MAX)
                    s_d.level = s_q.level + 3'h1;
                else if (!up && s_q.level != 3'h0)
                    s_d.level = s_q.level - 3'h1;
            end
        end
        else if (s_q.run)
        begin
            if (s_q.dcnt == '0)
            begin
                s_d.run       = 1'b0;
                s_d.start     = 1'b1;
                s_d.pending   = 1'b0;
                s_d.send_dest = s_q.freq_mod_ranging ? s_q.dest : DEST_DEFAULT;
            end
            else
                s_d.dcnt = s_q.dcnt - DW'(1);
        end

        // larger attenuation wins; limit 00 leaves the loop alone
        s_d.atten = (s_d.level > {1'b0, s_d.lim_q}) ? s_d.level : {1'b0, s_d.lim_q};

        // writes come last so a new command is never lost to the send
        if (bus.wr)
        begin
            if (bus.addr == REG_CTRL)
            begin
                s_d.hrr = bus.wdata[CTRL_HRR_BIT];
                s_d.freq_mod_ranging = bus.wdata[CTRL_FMR_BIT];
                if (bus.wdata[CTRL_HRR_BIT] != s_q.hrr || bus.wdata[CTRL_FMR_BIT] != s_q.freq_mod_ranging)
                    s_d.hcnt = 2'h0;
            end
            else if (bus.addr == REG_FREQ)
            begin
                s_d.freq    = bus.wdata[15:0];
                s_d.pending = 1'b1;
            end
            else if (bus.addr == REG_DEST)
                s_d.dest = bus.wdata[2:0];
            else if (bus.addr == REG_LIMIT)
                s_d.lim_reg = bus.wdata[1:0];
        end

        if (bus.rd)
        begin
            if (bus.addr == REG_CTRL)
                s_d.rdata = 32'({s_q.freq_mod_ranging, s_q.hrr});
            else if (bus.addr == REG_FREQ)
                s_d.rdata = 32'(s_q.freq);
            else if (bus.addr == REG_DEST)
                s_d.rdata = 32'(s_q.dest);
            else if (bus.addr == REG_LIMIT)
                s_d.rdata = 32'(s_q.lim_reg);
            else if (bus.addr == REG_STATUS)
                s_d.rdata = 32'({win_now, s_q.pending, s_q.hcnt, s_q.lim_q,
                                 s_q.level, s_q.atten});
            else
                s_d.rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q         <= '0;
            s_q.hrr     <= CTRL_RST;
            s_q.freq_mod_ranging     <= CTRL_RST;
            s_q.freq    <= FREQ_RST;
            s_q.dest    <= DEST_RST;
            s_q.lim_reg <= LIMIT_RST;
            s_q.lim_q   <= LIMIT_RST;
            s_q.level   <= LEVEL_RST;
            s_q.atten   <= LEVEL_RST;
            s_q.send_dest <= DEST_DEFAULT;
        end
        else
            s_q <= s_d;
    end

    occ_ser u_ser (
        .clock (clock),
        .rstn  (rstn),
        .start (s_q.start),
        .word  (s_q.freq),
        .dest  (s_q.send_dest),
        .osc   (osc)
    );

    assign win_now                   = osc.window;
    assign rdata                     = s_q.rdata;
    assign receiver_attenuation_code = s_q.atten;

    // cycles since the last phase edge, saturating
    logic [DW:0] since_q;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            since_q <= '1;
        else if (ph_evt)
            since_q <= '0;
        else if (since_q != '1)
            since_q <= since_q + (DW+1)'(1);
    end

    property p_delay;
        @(posedge clock) disable iff (!rstn)
        $rose(osc.window) |-> since_q == (DW+1)'(DELAY_CYCLES - 1);
    endproperty
    a_delay: assert property (p_delay) else $error("window delay wrong");

    property p_dest;
        @(posedge clock) disable iff (!rstn)
        $rose(osc.window) && !s_q.freq_mod_ranging |-> osc.dest == DEST_DEFAULT;
    endproperty
    a_dest: assert property (p_dest) else $error("destination code wrong");

    property p_pending;
        @(posedge clock) disable iff (!rstn)
        bus.wr && bus.addr == REG_FREQ |=> s_q.pending && s_q.freq == $past(bus.wdata[15:0]);
    endproperty
    a_pending: assert property (p_pending) else $error("command not taken");

    property p_limit_phase;
        @(posedge clock) disable iff (!rstn)
        $changed(s_q.lim_q) |-> $past(ph_evt);
    endproperty
    a_limit_phase: assert property (p_limit_phase) else $error("limit taken off phase");

    property p_mode_hold;
        @(posedge clock) disable iff (!rstn)
        $changed(s_q.level) |-> $past(s_q.hrr) && $past(s_q.hcnt) >= 2'h2;
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("level moved outside window");

    property p_one_step;
        @(posedge clock) disable iff (!rstn)
        $changed(s_q.level) |-> $past(ph_evt) &&
            (s_q.level == $past(s_q.level) + 3'h1 || s_q.level == $past(s_q.level) - 3'h1);
    endproperty
    a_one_step: assert property (p_one_step) else $error("level moved by more than one");

    property p_larger;
        @(posedge clock) disable iff (!rstn)
        s_q.atten >= s_q.level && s_q.atten >= {1'b0, s_q.lim_q} &&
            (s_q.atten == s_q.level || s_q.atten == {1'b0, s_q.lim_q});
    endproperty
    a_larger: assert property (p_larger) else $error("attenuation not the larger");

    property p_zero_limit;
        @(posedge clock) disable iff (!rstn)
        s_q.lim_q == 2'h0 |-> receiver_attenuation_code == s_q.level;
    endproperty
    a_zero_limit: assert property (p_zero_limit) else $error("zero limit not transparent");

    property p_out_timing;
        @(posedge clock) disable iff (!rstn)
        $changed(receiver_attenuation_code) |-> $past(ph_evt);
    endproperty
    a_out_timing: assert property (p_out_timing) else $error("output changed off phase");

    property p_direction;
        @(posedge clock) disable iff (!rstn)
        ph_evt && s_q.hrr && s_q.hcnt >= 2'h2 && up && s_q.level != LEVEL_MAX
            |=> s_q.level == $past(s_q.level) + 3'h1;
    endproperty
    a_direction: assert property (p_direction) else $error("no step up on hits");

    property p_range;
        @(posedge clock) disable iff (!rstn)
        s_q.level <= LEVEL_MAX && receiver_attenuation_code <= LEVEL_MAX;
    endproperty
    a_range: assert property (p_range) else $error("attenuation out of range");

    property p_run_needs_cmd;
        @(posedge clock) disable iff (!rstn)
        $rose(s_q.run) |-> $past(s_q.pending) && $past(ph_evt);
    endproperty
    a_run_needs_cmd: assert property (p_run_needs_cmd) else $error("send without command");

    property p_send_at_end;
        @(posedge clock) disable iff (!rstn)
        s_q.start |-> $past(s_q.run) && $past(s_q.dcnt) == '0;
    endproperty
    a_send_at_end: assert property (p_send_at_end) else $error("send before delay end");

    property p_data_quiet;
        @(posedge clock) disable iff (!rstn)
        !osc.window |-> !osc.data;
    endproperty
    a_data_quiet: assert property (p_data_quiet) else $error("data outside window");

    property p_hist_reset;
        @(posedge clock) disable iff (!rstn)
        bus.wr && bus.addr == REG_CTRL &&
            {bus.wdata[CTRL_FMR_BIT], bus.wdata[CTRL_HRR_BIT]} != {s_q.freq_mod_ranging, s_q.hrr}
            |=> s_q.hcnt == 2'h0;
    endproperty
    a_hist_reset: assert property (p_hist_reset) else $error("history not cleared");

    property p_hist_slide;
        @(posedge clock) disable iff (!rstn)
        ph_evt |=> s_q.h0 == $past(s_q.st_sync) && s_q.h1 == $past(s_q.h0) &&
            s_q.h2 == $past(s_q.h1);
    endproperty
    a_hist_slide: assert property (p_hist_slide) else $error("history not slid");

    property p_limit_copy;
        @(posedge clock) disable iff (!rstn)
        ph_evt |=> s_q.lim_q == $past(s_q.lim_reg);
    endproperty
    a_limit_copy: assert property (p_limit_copy) else $error("limit not taken at phase");

    property p_step_down;
        @(posedge clock) disable iff (!rstn)
        ph_evt && s_q.hrr && s_q.hcnt >= 2'h2 && !up && s_q.level != 3'h0
            |=> s_q.level == $past(s_q.level) - 3'h1;
    endproperty
    a_step_down: assert property (p_step_down) else $error("no step down without hits");

    property p_cov_down;
        @(posedge clock) disable iff (!rstn)
        s_q.level == 3'h1 ##1 s_q.level == 3'h0;
    endproperty
    c_cov_down: cover property (p_cov_down);

    property p_cov_up;
        @(posedge clock) disable iff (!rstn)
        s_q.level == 3'h2 ##1 s_q.level == 3'h3;
    endproperty
    c_cov_up: cover property (p_cov_up);

    property p_cov_sat;
        @(posedge clock) disable iff (!rstn)
        s_q.level == LEVEL_MAX;
    endproperty
    c_cov_sat: cover property (p_cov_sat);

    property p_cov_limit;
        @(posedge clock) disable iff (!rstn)
        s_q.lim_q > s_q.level[1:0] && s_q.level[2] == 1'b0;
    endproperty
    c_cov_limit: cover property (p_cov_limit);

endmodule

`default_nettype wire

// ===== occ_far.sv
// far-side model: event generator, analog holding register and apply strobe
`default_nettype none

module occ_far
    import occ_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     rstn,
    input  wire occ_osc_t osc,
    output logic          phase_start,
    output logic [1:0]    threshold_level_status,
    output logic [15:0]   held_word,
    output logic [2:0]    held_dest,
    output logic [15:0]   applied_word,
    output int            n_bits,
    output int            n_win,
    output int            win_len,
    output int            win_delay,
    output int            bad_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] shreg;
    logic        win_q;
    logic        ps_q;
    int          since;

    initial
    begin
        phase_start = 1'b0;
        threshold_level_status = 2'h0;
    end

    // level held after the pulse, as the analog side keeps it per phase
    task automatic phase(input logic [1:0] lvl, input int gap);
        @(posedge clock);
        phase_start <= 1'b1;
        threshold_level_status <= lvl;
        repeat (4) @(posedge clock);
        phase_start <= 1'b0;
        repeat (gap) @(posedge clock);
    endtask

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            {shreg, held_word, applied_word, win_q, ps_q} <= '0;
            held_dest <= 3'h0;
            {n_bits, n_win, win_len, win_delay, bad_cnt, since} <= '0;
        end
        else
        begin
            win_q <= osc.window;
            ps_q <= phase_start;
            since <= (phase_start && !ps_q) ? 1 : since + 1;
            if (phase_start && !ps_q)
                applied_word <= held_word;
            if (osc.window && !win_q)
            begin
                win_delay <= since;
                n_win <= n_win + 1;
                n_bits <= 0;
                win_len <= 0;
            end
            if (osc.window)
                win_len <= (win_q ? win_len : 0) + 1;
            if (osc.window && osc.shift)
            begin
                shreg <= {shreg[14:0], osc.data};
                n_bits <= (win_q ? n_bits : 0) + 1;
                held_dest <= osc.dest;
            end
            if (!osc.window && win_q)
                held_word <= shreg;
            if (!osc.window && osc.data)
                bad_cnt <= bad_cnt + 1;
        end
    end
endmodule

`default_nettype wire

// ===== testbench.sv
// self-checking bench of the oscillator command and gain control block
`default_nettype none

module testbench
    import occ_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DLY = 50;
    localparam int LONG = DLY + 2700;

    logic        clock;
    logic        rstn;
    occ_bus_t    bus;
    logic [31:0] rdata;
    occ_osc_t    osc;
    logic [2:0]  atten;
    logic        phase_start;
    logic [1:0]  tls;
    logic [15:0] held_word;
    logic [2:0]  held_dest;
    logic [15:0] applied_word;
    int          n_bits;
    int          n_win;
    int          win_len;
    int          win_delay;
    int          bad_cnt;
    int          error_cnt;
    int          n_tests;
    int          cyc;
    logic [2:0]  lvl_e;
    logic [2:0]  lim_e;
    logic [2:0]  lim_w;
    logic [1:0]  h [3];
    int          hist_n;
    logic [31:0] ctrl_w;
    logic [1:0]  seq [6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2};

    occ_ctrl #(.DELAY_CYCLES(DLY)) dut (
        .clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .phase_start(phase_start),
        .threshold_level_status(tls), .osc(osc), .receiver_attenuation_code(atten)
    );

    occ_far far (
        .clock(clock), .rstn(rstn), .osc(osc), .phase_start(phase_start),
        .threshold_level_status(tls), .held_word(held_word), .held_dest(held_dest),
        .applied_word(applied_word), .n_bits(n_bits), .n_win(n_win), .win_len(win_len),
        .win_delay(win_delay), .bad_cnt(bad_cnt)
    );

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic stop_test();
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
        if (a == REG_CTRL && d != ctrl_w)
            hist_n = 0;
        if (a == REG_CTRL)
            ctrl_w = d;
        if (a == REG_LIMIT)
            lim_w = {1'b0, d[1:0]};
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask

    // expected gain worked out per phase: limit latched and history slid at the event
    task automatic ph(input logic [1:0] s, input int gap);
        int nz;
        far.phase(s, gap);
        lim_e = lim_w;
        h[2] = h[1];
        h[1] = h[0];
        h[0] = s;
        if (hist_n < 3)
            hist_n++;
        nz = int'(h[0] != 0) + int'(h[1] != 0) + int'(h[2] != 0);
        if (ctrl_w[0] && hist_n == 3)
        begin
            if (nz >= 2 && lvl_e < 3'h4)
                lvl_e++;
            else if (nz < 2 && lvl_e > 3'h0)
                lvl_e--;
        end
        chk("atten", (lvl_e > lim_e) ? lvl_e : lim_e, atten);
    endtask

    task automatic send(input logic [31:0] ctrl, input logic [15:0] w, input logic [2:0] dexp);
        wr(REG_CTRL, ctrl);
        wr(REG_FREQ, {16'h0, w});
        rdchk("pending", REG_STATUS, {20'h0, 1'b0, 1'b1, 2'(hist_n), lim_e[1:0], lvl_e,
            (lvl_e > lim_e) ? lvl_e : lim_e});
        ph(2'h0, LONG);
        chk("word", w, held_word);
        chk("dest", dexp, held_dest);
        chk("bits", 16, n_bits);
        chk("win_len", ENV_CYC, win_len);
        chk("delay_ok", 1, win_delay >= DLY && win_delay <= DLY + 4);
        chk("not_applied", 1, applied_word !== w);
    endtask

    initial
    begin
        rstn = 1'b0;
        bus = '0;
        {error_cnt, n_tests, cyc, hist_n} = '0;
        {lvl_e, lim_e, lim_w} = '0;
        ctrl_w = 32'h0;
        h = '{2'h0, 2'h0, 2'h0};
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        chk("dest_rst", DEST_RST, osc.dest);
        chk("atten_rst", 3'h0, atten);
        rdchk("ctrl_rst", REG_CTRL, 32'h0);
        rdchk("status_rst", REG_STATUS, 32'h0);
        rdchk("unmapped", 8'h20, 32'h0);
        wr(REG_LIMIT, 32'h0);
        send(32'h1, 16'ha5c3, DEST_DEFAULT);
        ph(2'h0, 30);
        chk("applied", 16'ha5c3, applied_word);
        chk("one_send", 1, n_win);
        foreach (seq[i])
            ph(seq[i], 30);
        repeat (3)
            ph(2'h0, 30);
        // level below the new limit, so an early take-over would show
        wr(REG_LIMIT, 32'h3);
        rdchk("limit_reg", REG_LIMIT, 32'h3);
        chk("limit_wait", 3'h2, atten);
        repeat (3)
            ph(2'h0, 30);
        wr(REG_LIMIT, 32'h0);
        ph(2'h0, 30);
        wr(REG_DEST, 32'h2);
        rdchk("dest_reg", REG_DEST, 32'h2);
        send(32'h3, 16'h3c5a, 3'h2);
        send(32'h1, 16'h0001, DEST_DEFAULT);
        rdchk("freq_reg", REG_FREQ, 32'h1);
        rdchk("ctrl_reg", REG_CTRL, 32'h1);
        wr(REG_CTRL, 32'h0);
        repeat (4)
            ph(2'h3, 30);
        chk("quiet_line", 0, bad_cnt);
        stop_test();
    end
endmodule

`default_nettype wire
